/* dsi_interlock.sv */
`timescale 1ns/1ps
`include "dsi_cfg.svh"
// How it works
// - any channel low forces machine safe
// - both channels sampled and judged separately
// - flag channels that carry different levels
// - disagreement tolerated only up to discrepancy time
// - restart interlock is built here, outside sensor
// - after interruption, wait for reset button press
// - mode change also demands a reset press
// - feedback must show drop-out after switch-off
// - switch-on only with contactors dropped out
// - field interrupted de-energizes both contactors
// - cross and short circuits lead to locking
// - contactor that fails to drop is fault
module dsi_interlock #(
	parameter int DISC_CYC = `DSI_DISC_TIME_US * `DSI_CLK_MHZ,
	parameter int DROP_CYC = `DSI_DROP_TIME_US * `DSI_CLK_MHZ,
	parameter int PULL_CYC = `DSI_PULL_TIME_US * `DSI_CLK_MHZ,
	parameter int BTN_CYC  = `DSI_BTN_FILT_CYC
) (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire dsi_pkg::dsi_chan_t  safety_switching_output,
	input  wire dsi_pkg::dsi_fb_t    contactor_feedback_monitor,
	input  wire logic                reset_button,
	input  wire logic                mode_change,
	input  wire logic                fault_reset,
	output logic                     main_contactor_a,
	output logic                     main_contactor_b,
	output logic                     machine_enable,
	output logic                     locked,
	output dsi_pkg::dsi_fault_t      fault_code
);
	import dsi_pkg::*;

	// timers are 32 bits so the long contactor spans still fit at 100 MHz
	localparam int CW    = 32;
	// synchronised pins: two channels, two feedbacks, three control pins
	localparam int NSYNC = 7;

	logic [NSYNC-1:0] pin_raw, pin_sync;
	dsi_chan_t  chan_q;
	dsi_fb_t    fb_q;
	logic [2:0] btn_q;
	dsi_state_t state_q;
	logic [CW-1:0] disc_cnt_q, tmr_q, btn_cnt_q;
	logic       btn_armed_q, btn_press_q;
	logic       ch_a, ch_b, both_on, any_off, disagree, fb_out, fb_split;

	// raw pin bundle: channels, feedback, then fault reset, mode change, button
	assign pin_raw = {safety_switching_output, contactor_feedback_monitor,
		fault_reset, mode_change, reset_button};

	// one two-flop synchroniser per pin bit; only the second flop is read, so
	// a metastable first flop never reaches the decision logic
	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		logic meta_q, sync_q;

		always_ff @(posedge clk) begin
			if (!rstn) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= pin_raw[i];
				sync_q <= meta_q;
			end
		end
		assign pin_sync[i] = sync_q;
	end

	// unpack the synchronised bits back into the carrier types
	assign chan_q = dsi_chan_t'(pin_sync[6:5]);
	assign fb_q   = dsi_fb_t'(pin_sync[4:3]);
	assign btn_q  = pin_sync[2:0];

	// channels stay separate bits; never a wired combination
	// feedback high means the contactor has dropped out, auxiliary contact closed
	assign ch_a     = chan_q.safety_output_channel_a;
	assign ch_b     = chan_q.safety_output_channel_b;
	assign both_on  = ch_a & ch_b;
	assign any_off  = ~ch_a | ~ch_b;
	assign disagree = ch_a ^ ch_b;
	assign fb_out   = fb_q.main_contactor_a & fb_q.main_contactor_b;
	assign fb_split = fb_q.main_contactor_a ^ fb_q.main_contactor_b;

	// discrepancy timer; a normal switch edge may skew briefly between channels
	// it saturates at the limit so it can never wrap back under it
	always_ff @(posedge clk) begin
		if (!rstn)
			disc_cnt_q <= '0;
		else if (!disagree)
			disc_cnt_q <= '0;
		else if (disc_cnt_q < CW'(DISC_CYC))
			disc_cnt_q <= disc_cnt_q + 1'b1;
	end

	// button must be seen released, then held BTN_CYC cycles: a stuck button
	// never counts, so a welded pushbutton cannot restart the machine
	always_ff @(posedge clk) begin
		if (!rstn) begin
			btn_cnt_q   <= '0;
			btn_armed_q <= 1'b0;
			btn_press_q <= 1'b0;
		end else begin
			// the press is a one-cycle pulse; a state not waiting for it drops it,
			// so a press made too early has to be repeated
			btn_press_q <= 1'b0;
			if (!btn_q[0]) begin
				btn_cnt_q   <= '0;
				btn_armed_q <= 1'b1;
			end else if (btn_armed_q) begin
				if (btn_cnt_q >= CW'(BTN_CYC - 1)) begin
					btn_press_q <= 1'b1;
					btn_armed_q <= 1'b0;
				end else begin
					btn_cnt_q <= btn_cnt_q + 1'b1;
				end
			end
		end
	end

	// contactor timer, restarted on each state change
	// one timer serves pull-in and drop-out, as only one is ever awaited
	dsi_state_t state_d;
	logic [CW-1:0] tmr_d;
	dsi_fault_t fault_d;

	always_comb begin
		state_d = state_q;
		fault_d = DSI_FLT_NONE;
		case (state_q)
			// safe: coils off; wait for both channels on and both contactors out,
			// and lock if the channels disagree too long or the feedback splits
			DSI_SAFE: begin
				if (disc_cnt_q >= CW'(DISC_CYC))
					fault_d = DSI_FLT_DISCREP;
				else if (fb_split)
					fault_d = DSI_FLT_FB_SPLIT;
				else if (both_on && fb_out)
					state_d = DSI_READY;
			end
			// ready: armed for a reset press, back to safe if a channel drops or a feedback leaves drop-out
			DSI_READY: begin
				if (any_off || !fb_out)
					state_d = DSI_SAFE;
				else if (btn_press_q && !btn_q[1])
					state_d = DSI_RUN;
			end
			// run: any channel off or a mode change drops the coils at once
			DSI_RUN: begin
				if (any_off || btn_q[1]) begin
					state_d = DSI_DROP;
				end else if (fb_q.main_contactor_a | fb_q.main_contactor_b) begin
					// still dropped out after the pull-in time: a broken coil or
					// auxiliary contact, so that feedback can no longer be trusted
					if (tmr_q >= CW'(PULL_CYC))
						fault_d = DSI_FLT_NO_PULL;
				end
			end
			// drop: coils off; both auxiliary contacts must report drop-out
			// within the drop time, otherwise a contact is taken as welded
			DSI_DROP: begin
				if (fb_out)
					state_d = DSI_SAFE;
				else if (tmr_q >= CW'(DROP_CYC))
					fault_d = DSI_FLT_NO_DROP;
			end
			// locked: coils stay off; only a fault reset with both channels on
			// and equal leaves, and then only to safe, never straight to run
			DSI_LOCKED: begin
				if (btn_q[2] && !any_off && !disagree)
					state_d = DSI_SAFE;
			end
			// an illegal state code is treated as a fault and locks
			default:
				state_d = DSI_LOCKED;
		endcase
		// any fault overrides the move chosen above and locks
		if (fault_d != DSI_FLT_NONE)
			state_d = DSI_LOCKED;
		// timer saturates instead of wrapping, so a long stay never looks fresh
		tmr_d = (state_d != state_q) ? '0 : tmr_q + ((tmr_q == '1) ? CW'(0) : CW'(1));
	end

	// main state; no internal restart interlock in the sensor, so it lives here
	// reset lands in safe, so a power-up never starts the machine by itself
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= DSI_SAFE;
			tmr_q   <= '0;
		end else begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
		end
	end

	// registered outputs; contactors only energised in RUN with both channels on
	always_ff @(posedge clk) begin
		if (!rstn) begin
			main_contactor_a <= 1'b0;
			main_contactor_b <= 1'b0;
			machine_enable   <= 1'b0;
			locked           <= 1'b0;
			fault_code       <= DSI_FLT_NONE;
		end else begin
			main_contactor_a <= (state_d == DSI_RUN);
			main_contactor_b <= (state_d == DSI_RUN);
			machine_enable   <= (state_d == DSI_RUN);
			locked           <= (state_d == DSI_LOCKED);
			// the code latches the cause and holds it for as long as it locks
			if (fault_d != DSI_FLT_NONE)
				fault_code <= fault_d;
			else if (state_d != DSI_LOCKED)
				fault_code <= DSI_FLT_NONE;
		end
	end

endmodule

/* dsi_cfg.svh */
`ifndef DSI_CFG_SVH
`define DSI_CFG_SVH

// default time the two channels may disagree, in microseconds
`define DSI_DISC_TIME_US      10000
// time a contactor may take to drop out after switch-off, in microseconds
`define DSI_DROP_TIME_US      50000
// time a contactor may take to pull in after switch-on, in microseconds
`define DSI_PULL_TIME_US      50000
`define DSI_CLK_MHZ           100
// least cycles for a reset button level to count as pressed
`define DSI_BTN_FILT_CYC      16

`endif

/* dsi_pkg.sv */
package dsi_pkg;

	typedef enum logic [2:0] {
		DSI_SAFE   = 3'b000,
		DSI_READY  = 3'b001,
		DSI_RUN    = 3'b011,
		DSI_DROP   = 3'b010,
		DSI_LOCKED = 3'b110
	} dsi_state_t;

	// the two sensor channels, kept apart as two separate bits
	typedef struct packed {
		logic safety_output_channel_a;
		logic safety_output_channel_b;
	} dsi_chan_t;

	// auxiliary contact feedback, high while the contactor is dropped out
	typedef struct packed {
		logic main_contactor_a;
		logic main_contactor_b;
	} dsi_fb_t;

	typedef enum logic [2:0] {
		DSI_FLT_NONE     = 3'h0,
		DSI_FLT_DISCREP  = 3'h1,
		DSI_FLT_NO_DROP  = 3'h2,
		DSI_FLT_NO_PULL  = 3'h3,
		DSI_FLT_FB_SPLIT = 3'h4
	} dsi_fault_t;

endpackage

/* dsi_interlock_assertions.sv */
`timescale 1ns/1ps
module dsi_checker (
	input logic                clk,
	input logic                rstn,
	input dsi_pkg::dsi_chan_t  safety_switching_output,
	input dsi_pkg::dsi_fb_t    contactor_feedback_monitor,
	input logic                reset_button,
	input logic                mode_change,
	input logic                fault_reset,
	input logic                main_contactor_a,
	input logic                main_contactor_b,
	input logic                machine_enable,
	input logic                locked,
	input dsi_pkg::dsi_fault_t fault_code
);
	import dsi_pkg::*;
	// short aliases; pins are async, so start checks look three cycles back
	wire on = &safety_switching_output;
	wire fo = &contactor_feedback_monitor;
	wire ca = main_contactor_a;
	wire cb = main_contactor_b;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_off_drop: assert property ((!on)[*4] |-> !ca && !cb) else $error("no stop");
	a_pair_same: assert property (ca == cb) else $error("split coils");
	a_run_coils: assert property (machine_enable |-> ca && cb) else $error("bad run");
	a_lock_off: assert property (locked |-> !ca && !machine_enable) else $error("lock on");
	a_lock_code: assert property (locked |-> fault_code != DSI_FLT_NONE) else $error("no code");
	a_lock_hold: assert property ((!fault_reset)[*4] ##0 locked |=> locked) else $error("left");
	a_start_ok: assert property ($rose(ca) |-> $past(on, 3) && $past(fo, 3)) else $error("start");
	a_mode_stop: assert property (mode_change[*4] |-> !machine_enable) else $error("mode");
	c_run: cover property ($rose(machine_enable));
	c_lock: cover property ($rose(locked));
	c_drop: cover property (fault_code == DSI_FLT_NO_DROP);
	c_pull: cover property (fault_code == DSI_FLT_NO_PULL);
endmodule
bind dsi_interlock dsi_checker u_chk (.*);

/* dsi_sensor_model.sv */
`timescale 1ns/1ps
// receiver outputs: a break or an internal fault drops both channels
module dsi_sensor_model (
	input logic                fld,
	input logic                dev_flt,
	input logic                short_b,
	output dsi_pkg::dsi_chan_t chan
);
	import dsi_pkg::*;
	wire on = fld && !dev_flt;
	// short_b is a cross-circuit that holds channel b high
	assign chan = {on, on || short_b};
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
	import dsi_pkg::*;
	logic        clk = 1'h0, rstn = 1'h0, reset_button = 1'h0;
	logic        mode_change = 1'h0, fault_reset = 1'h0, weld_a = 1'h0;
	logic        fld = 1'h1, dev_flt = 1'h0, short_b = 1'h0, open_b = 1'h0;
	logic        main_contactor_a, main_contactor_b, machine_enable, locked;
	logic [2:0]  qa = 3'h0, qb = 3'h0;
	logic [31:0] rnd = 32'h0dda;
	int          n_errors = 0, comparisons = 0;
	dsi_chan_t   safety_switching_output;
	dsi_fb_t     contactor_feedback_monitor;
	dsi_fault_t  fault_code;
	dsi_interlock #(.DISC_CYC(20), .DROP_CYC(40), .PULL_CYC(40), .BTN_CYC(2)) uut (.*);
	dsi_sensor_model sen (.fld(fld), .dev_flt(dev_flt), .short_b(short_b),
		.chan(safety_switching_output));
	initial forever #5 clk = ~clk;
	// armatures lag their coils three cycles; a welded one never drops out
	always @(negedge clk) qa <= {qa[1:0], main_contactor_a};
	always @(negedge clk) qb <= {qb[1:0], main_contactor_b};
	// open_b is an auxiliary contact of b that always reports dropped out
	assign contactor_feedback_monitor = {!(qa[2] || weld_a), !qb[2] || open_b};
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	// settle first, so the press never lands before the ready state
	task automatic press();
		tick(6);
		reset_button = 1'h1;
		tick(6);
		reset_button = 1'h0;
		tick(6);
	endtask
	task automatic unlock();
		fault_reset = 1'h1;
		tick(6);
		fault_reset = 1'h0;
		tick(6);
		`CHK("locked", 1'h0, locked)
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// the tests need under 1500 cycles; 10000 means a hang
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	initial begin
		tick(8);
		`CHK("reset", 1'h0, main_contactor_a)
		rstn = 1'h1;
		// random short breaks, by beam or by fault, must latch the stop
		for (int i = 0; i < 6; i++) begin
			press();
			`CHK("run", 1'h1, machine_enable)
			`CHK("run_a", 1'h1, main_contactor_a)
			rnd = lfsr(rnd);
			// even rounds break the beam, odd rounds raise a sensor fault
			dev_flt = i[0];
			fld = i[0];
			tick(rnd[2:0] + 1);
			dev_flt = 1'h0;
			fld = 1'h1;
			tick(6);
			`CHK("stop", 1'h0, main_contactor_b)
		end
		$display("test breaks done");
		press();
		mode_change = 1'h1;
		tick(6);
		mode_change = 1'h0;
		`CHK("mode", 1'h0, machine_enable)
		fld = 1'h0;
		press();
		`CHK("refused", 1'h0, machine_enable)
		fld = 1'h1;
		$display("test mode done");
		press();
		weld_a = 1'h1;
		fld = 1'h0;
		tick(60);
		`CHK("weld", DSI_FLT_NO_DROP, fault_code)
		weld_a = 1'h0;
		fld = 1'h1;
		unlock();
		$display("test weld done");
		fld = 1'h0;
		short_b = 1'h1;
		tick(10);
		short_b = 1'h0;
		tick(10);
		`CHK("brief", 1'h0, locked)
		short_b = 1'h1;
		tick(40);
		`CHK("cross", DSI_FLT_DISCREP, fault_code)
		short_b = 1'h0;
		fld = 1'h1;
		unlock();
		$display("test cross done");
		// a welded contact splits the feedback while waiting to start
		weld_a = 1'h1;
		tick(10);
		`CHK("split", DSI_FLT_FB_SPLIT, fault_code)
		weld_a = 1'h0;
		unlock();
		// a contact stuck closed makes a pulled-in contactor look as if it never pulls in
		open_b = 1'h1;
		press();
		tick(40);
		`CHK("pull", DSI_FLT_NO_PULL, fault_code)
		`CHK("pull_off", 1'h0, main_contactor_a)
		open_b = 1'h0;
		unlock();
		$display("test contactor done");
		give_verdict();
	end
endmodule
